// ### hw/vic_pkg.sv
// constants shared by the vectored interrupt controller files
package vic_pkg;
   localparam int NUM_EXT = 4;
   localparam int MAX_SRC = 16;
   localparam int PRIO_W = 3;
   localparam int SRC_W = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int OWN_W = 5;
   localparam int STS_W = 2;

   localparam logic [ADDR_W-1:0] OFS_OWN    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EDGE   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_POL    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PRIO0  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PRIO1  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PEND   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_VECTOR = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h24;

   localparam logic [OWN_W-1:0]   RST_OWN    = 5'h00;
   localparam logic [MAX_SRC-1:0] RST_ENABLE = 16'h0000;
   localparam logic [MAX_SRC-1:0] RST_EDGE   = 16'h0000;
   localparam logic [MAX_SRC-1:0] RST_POL    = 16'hFFFF;
   localparam logic [MAX_SRC*PRIO_W-1:0] RST_PRIO = 48'h0;
   localparam logic [STS_W-1:0]   RST_STS    = 2'h0;

   localparam int OWN_FAST_BIT  = 4;
   localparam int VEC_VALID_BIT = 31;
   localparam int VEC_PRIO_LSB  = 8;
   localparam int STS_STD_BIT   = 0;
   localparam int STS_FAST_BIT  = 1;
   localparam int PRIO_PER_WORD = 8;
endpackage

// ### hw/vic_src_detect.sv
// per-source level or edge detector with sticky edge latch
`timescale 1ns/1ps
`default_nettype none
module vic_src_detect (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic level_in,
   input  wire logic src_en,
   input  wire logic edge_mode,
   input  wire logic active_high,
   input  wire logic clear,
   output logic      pending
);
   logic in_q;
   logic latch_q;
   logic hit;
   logic was_hit;
   logic edge_seen;

   assign hit       = (level_in == active_high);
   assign was_hit   = (in_q == active_high);
   assign edge_seen = src_en && edge_mode && hit && !was_hit;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         in_q <= 1'b0;
      end else if (clk_en) begin
         in_q <= level_in;
      end
   end

   // a new edge beats a clear in the same cycle
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         latch_q <= 1'b0;
      end else if (clk_en) begin
         if (edge_seen) begin
            latch_q <= 1'b1;
         end else if (clear || !src_en || !edge_mode) begin
            latch_q <= 1'b0;
         end
      end
   end

   assign pending = src_en && (edge_mode ? latch_q : was_hit);

   sequence s_edge_in;
      clk_en && src_en && edge_mode && !was_hit && hit;
   endsequence

   chk_edge_catch: assert property (@(posedge clock) disable iff (sys_rst)
      s_edge_in |=> (latch_q || !clk_en))
      else $error("edge not latched");

   chk_edge_sticky: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && src_en && edge_mode && latch_q && !clear) ##1 (src_en && edge_mode)
      |-> pending)
      else $error("edge pending dropped without clear");

   chk_level_follow: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && hit) ##1 (src_en && !edge_mode && $stable(active_high)) |-> pending)
      else $error("level source not pending");
endmodule
`default_nettype wire

// ### hw/vic_top.sv
// vectored priority interrupt controller top with register port
// Function
// - eight-level priority picks highest pending source
// - each source masked on its own
// - fast output driven only by fast pin
// - standard output on any enabled pending source
// - internal sources level or edge selectable
// - external standard pins rising, falling, high, low; fast pin high level only
// - pins owned by general io after reset
`timescale 1ns/1ps
`default_nettype none
module vic_top #(
   parameter int NUM_INT = 12
) (
   input  wire logic                        clock,
   input  wire logic                        sys_rst,
   input  wire logic                        clk_en,
   input  wire logic [NUM_INT-1:0]          int_src,
   input  wire logic [vic_pkg::NUM_EXT-1:0] ext_std_request,
   input  wire logic                        ext_fast_request,
   input  wire logic [vic_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [vic_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [vic_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic                        vec_req,
   output logic      [vic_pkg::SRC_W-1:0]   vec_src,
   output logic      [vic_pkg::PRIO_W-1:0]  vec_prio,
   output logic                             vec_valid,
   output logic                             core_fast_irq_n,
   output logic                             core_std_irq_n,
   output logic      [vic_pkg::OWN_W-1:0]   general_io_controller_owns,
   output logic                             ctrl_irq
);
   import vic_pkg::*;

   localparam int NSRC = NUM_INT + NUM_EXT;
   localparam int PW = MAX_SRC * PRIO_W;
   localparam int BW = 1 + PRIO_W + SRC_W;

   logic [OWN_W-1:0]   own_q;
   logic [MAX_SRC-1:0] enable_q;
   logic [MAX_SRC-1:0] edge_q;
   logic [MAX_SRC-1:0] pol_q;
   logic [PW-1:0]      prio_q;
   logic [STS_W-1:0]   sts_q;
   logic [STS_W-1:0]   sts_set;
   logic [STS_W-1:0]   mask_q;
   logic [NUM_EXT:0]   pin_s1_q;
   logic [NUM_EXT:0]   pin_s2_q;
   logic [MAX_SRC-1:0] src_level;
   logic [MAX_SRC-1:0] src_on;
   logic [MAX_SRC-1:0] pend;
   logic [MAX_SRC-1:0] active;
   logic [MAX_SRC-1:0] clr_src;
   logic [BW-1:0]      best;
   logic               fast_q;
   logic               std_q;
   logic               irq_q;
   logic               wr_en;
   logic               vec_take;
   logic               rd_vec;
   logic [DATA_W-1:0]  rd_d;

   // highest priority wins, strict compare keeps the lowest number on ties
   function automatic logic [BW-1:0] pick_best(input logic [MAX_SRC-1:0] act,
                                               input logic [PW-1:0] prio);
      logic              found;
      logic [PRIO_W-1:0] bp;
      logic [SRC_W-1:0]  bi;
      found = 1'b0;
      bp = '0;
      bi = '0;
      for (int i = 0; i < MAX_SRC; i++) begin
         if (act[i] && (!found || prio[i*PRIO_W +: PRIO_W] > bp)) begin
            found = 1'b1;
            bp = prio[i*PRIO_W +: PRIO_W];
            bi = SRC_W'(i);
         end
      end
      return {found, bp, bi};
   endfunction

   assign wr_en = clk_en && reg_wr;
   assign rd_vec = reg_rd && (reg_addr == OFS_VECTOR);
   assign vec_take = clk_en && (vec_req || rd_vec);

   // external pins come from outside the clock domain
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else if (clk_en) begin
         pin_s1_q <= {ext_fast_request, ext_std_request};
         pin_s2_q <= pin_s1_q;
      end
   end

   always_comb begin
      src_level = '0;
      src_on = '0;
      src_level[NUM_INT-1:0] = int_src;
      src_on[NUM_INT-1:0] = '1;
      for (int e = 0; e < NUM_EXT; e++) begin
         src_level[NUM_INT+e] = pin_s2_q[e];
         src_on[NUM_INT+e] = own_q[e];
      end
   end

   // vectoring the edge source acknowledges it
   always_comb begin
      clr_src = '0;
      if (wr_en && reg_addr == OFS_PEND) begin
         clr_src = reg_wdata[MAX_SRC-1:0];
      end
      if (vec_take && best[BW-1]) begin
         clr_src[best[SRC_W-1:0]] = 1'b1;
      end
   end

   for (genvar g = 0; g < MAX_SRC; g++) begin : g_src
      if (g < NSRC) begin : g_used
         vic_src_detect u_det (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .clk_en      (clk_en),
            .level_in    (src_level[g]),
            .src_en      (src_on[g]),
            .edge_mode   (edge_q[g]),
            .active_high (g < NUM_INT ? 1'b1 : pol_q[g]),
            .clear       (clr_src[g]),
            .pending     (pend[g])
         );
      end else begin : g_none
         assign pend[g] = 1'b0;
      end
   end

   assign active = pend & enable_q;
   assign best = pick_best(active, prio_q);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         own_q <= RST_OWN;
      end else if (wr_en && reg_addr == OFS_OWN) begin
         own_q <= reg_wdata[OWN_W-1:0];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         enable_q <= RST_ENABLE;
         edge_q <= RST_EDGE;
         pol_q <= RST_POL;
         mask_q <= RST_STS;
      end else if (wr_en) begin
         if (reg_addr == OFS_ENABLE) begin
            enable_q <= reg_wdata[MAX_SRC-1:0];
         end
         if (reg_addr == OFS_EDGE) begin
            edge_q <= reg_wdata[MAX_SRC-1:0];
         end
         if (reg_addr == OFS_POL) begin
            pol_q <= reg_wdata[MAX_SRC-1:0];
         end
         if (reg_addr == OFS_MASK) begin
            mask_q <= reg_wdata[STS_W-1:0];
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prio_q <= RST_PRIO;
      end else if (wr_en) begin
         if (reg_addr == OFS_PRIO0) begin
            prio_q[0 +: PRIO_PER_WORD*PRIO_W] <= reg_wdata[PRIO_PER_WORD*PRIO_W-1:0];
         end
         if (reg_addr == OFS_PRIO1) begin
            prio_q[PRIO_PER_WORD*PRIO_W +: PRIO_PER_WORD*PRIO_W] <=
               reg_wdata[PRIO_PER_WORD*PRIO_W-1:0];
         end
      end
   end

   // core request lines, active low
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         fast_q <= 1'b0;
         std_q <= 1'b0;
      end else if (clk_en) begin
         fast_q <= pin_s2_q[NUM_EXT] && own_q[OWN_FAST_BIT];
         std_q <= |active;
      end
   end

   assign core_fast_irq_n = !fast_q;
   assign core_std_irq_n = !std_q;
   assign general_io_controller_owns = ~own_q;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         vec_src <= '0;
         vec_prio <= '0;
         vec_valid <= 1'b0;
      end else if (vec_take) begin
         vec_src <= best[SRC_W-1:0];
         vec_prio <= best[SRC_W +: PRIO_W];
         vec_valid <= best[BW-1];
      end
   end

   // sticky events: a new event beats a write-one clear
   assign sts_set[STS_STD_BIT] = clk_en && (|active) && !std_q;
   assign sts_set[STS_FAST_BIT] = clk_en && pin_s2_q[NUM_EXT] && own_q[OWN_FAST_BIT] && !fast_q;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sts_q <= RST_STS;
      end else if (clk_en) begin
         if (wr_en && reg_addr == OFS_STATUS) begin
            sts_q <= (sts_q & ~reg_wdata[STS_W-1:0]) | sts_set;
         end else begin
            sts_q <= sts_q | sts_set;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(sts_q & mask_q);
      end
   end

   assign ctrl_irq = irq_q;

   always_comb begin
      rd_d = '0;
      case (reg_addr)
         OFS_OWN:    rd_d[OWN_W-1:0] = own_q;
         OFS_ENABLE: rd_d[MAX_SRC-1:0] = enable_q;
         OFS_EDGE:   rd_d[MAX_SRC-1:0] = edge_q;
         OFS_POL:    rd_d[MAX_SRC-1:0] = pol_q;
         OFS_PRIO0:  rd_d[PRIO_PER_WORD*PRIO_W-1:0] = prio_q[0 +: PRIO_PER_WORD*PRIO_W];
         OFS_PRIO1:  rd_d[PRIO_PER_WORD*PRIO_W-1:0] =
                        prio_q[PRIO_PER_WORD*PRIO_W +: PRIO_PER_WORD*PRIO_W];
         OFS_PEND:   rd_d[MAX_SRC-1:0] = pend;
         OFS_VECTOR: begin
            rd_d[VEC_VALID_BIT] = best[BW-1];
            rd_d[VEC_PRIO_LSB +: PRIO_W] = best[SRC_W +: PRIO_W];
            rd_d[SRC_W-1:0] = best[SRC_W-1:0];
         end
         OFS_STATUS: rd_d[STS_W-1:0] = sts_q;
         OFS_MASK:   rd_d[STS_W-1:0] = mask_q;
         default:    rd_d = '0;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rd_d : '0;
      end
   end

   // helper: any active source above the chosen priority, or at the same priority with a lower number
   logic prio_violation;
   always_comb begin
      prio_violation = 1'b0;
      for (int i = 0; i < MAX_SRC; i++) begin
         if (active[i] && prio_q[i*PRIO_W +: PRIO_W] > best[SRC_W +: PRIO_W]) begin
            prio_violation = 1'b1;
         end
         if (active[i] && prio_q[i*PRIO_W +: PRIO_W] == best[SRC_W +: PRIO_W]
             && SRC_W'(i) < best[SRC_W-1:0]) begin
            prio_violation = 1'b1;
         end
      end
   end

   chk_vec_highest: assert property (@(posedge clock) disable iff (sys_rst)
      !prio_violation)
      else $error("vector not highest priority");

   chk_vec_source: assert property (@(posedge clock) disable iff (sys_rst)
      vec_take |=> (vec_valid == $past(|active)) && (!vec_valid || $past(active[best[SRC_W-1:0]])))
      else $error("vector names no active source");

   chk_fast_only_pin: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en |=> core_fast_irq_n == !$past(pin_s2_q[NUM_EXT] && own_q[OWN_FAST_BIT]))
      else $error("fast output not from fast pin");

   chk_mask_blocks: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && (pend & enable_q) == '0) |=> core_std_irq_n)
      else $error("masked source raised request");

   chk_std_assert: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && |active) |=> !core_std_irq_n)
      else $error("standard request missing");

   chk_own_hold: assert property (@(posedge clock) disable iff (sys_rst)
      !(wr_en && reg_addr == OFS_OWN) |=> $stable(own_q))
      else $error("pin ownership changed without write");

   chk_own_gate: assert property (@(posedge clock) disable iff (sys_rst)
      !own_q[OWN_FAST_BIT] [*2] |-> core_fast_irq_n)
      else $error("fast request while pin owned by io");
endmodule
`default_nettype wire

// ### verification/vic_core_model.sv
// processor core model: fetches a vector while the standard request is low
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
   input  wire logic                      clock,
   input  wire logic                      sys_rst,
   input  wire logic                      ack_on,
   input  wire logic [3:0]                ack_wait,
   input  wire logic                      core_std_irq_n,
   input  wire logic [vic_pkg::SRC_W-1:0] vec_src,
   output logic                           vec_req,
   output logic                           taken,
   output logic      [vic_pkg::SRC_W-1:0] taken_src
);
   import vic_pkg::*;
   logic [3:0] wait_q;
   logic       req_q;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wait_q <= 4'h0;
         vec_req <= 1'b0;
         req_q <= 1'b0;
         taken <= 1'b0;
         taken_src <= '0;
      end else begin
         vec_req <= 1'b0;
         req_q <= vec_req;
         if (!ack_on) begin
            taken <= 1'b0;
            wait_q <= 4'h0;
         end else if (!core_std_irq_n && !taken && !vec_req && !req_q) begin
            // a slow core lets the request stand ack_wait cycles first
            if (wait_q == ack_wait) begin
               vec_req <= 1'b1;
               wait_q <= 4'h0;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
         if (req_q) begin
            taken <= 1'b1;
            taken_src <= vec_src;
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/vic_top_test.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_top_test;
   import vic_pkg::*;
   localparam int NI = 12;
   logic                clock = 1'b0;
   logic                sys_rst = 1'b1;
   logic [NI-1:0]       int_src = '0;
   logic [NUM_EXT-1:0]  ext_std_request = '0;
   logic                ext_fast_request = 1'b0;
   logic [ADDR_W-1:0]   reg_addr = '0;
   logic [DATA_W-1:0]   reg_wdata = '0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic                clk_en = 1'b1;
   logic                ack_on = 1'b0;
   logic [3:0]          ack_wait = 4'h0;
   logic [DATA_W-1:0]   reg_rdata;
   logic                vec_req;
   logic                vec_valid;
   logic                fast_n;
   logic                std_n;
   logic                ctrl_irq;
   logic                taken;
   logic [SRC_W-1:0]    vec_src;
   logic [SRC_W-1:0]    taken_src;
   logic [PRIO_W-1:0]   vec_prio;
   logic [OWN_W-1:0]    owns;
   int                  n_mismatch = 0;
   int                  comparisons = 0;

   always #5 clock = ~clock;

   vic_top #(.NUM_INT(NI)) i_vic_top (
      .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .int_src(int_src),
      .ext_std_request(ext_std_request), .ext_fast_request(ext_fast_request),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .vec_req(vec_req), .vec_src(vec_src), .vec_prio(vec_prio),
      .vec_valid(vec_valid), .core_fast_irq_n(fast_n), .core_std_irq_n(std_n),
      .general_io_controller_owns(owns), .ctrl_irq(ctrl_irq));

   vic_core_model i_vic_core_model (
      .clock(clock), .sys_rst(sys_rst), .ack_on(ack_on), .ack_wait(ack_wait),
      .core_std_irq_n(std_n), .vec_src(vec_src), .vec_req(vec_req),
      .taken(taken), .taken_src(taken_src));

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string w);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      // read data stand for one cycle only, so look mid-cycle
      @(negedge clock);
      check(w, e, reg_rdata);
      @(posedge clock);
   endtask

   task automatic take_vector();
      ack_on <= 1'b1;
      for (int i = 0; i < 40 && taken !== 1'b1; i++) cyc(1);
      check("taken", 32'h1, 32'(taken));
      ack_on <= 1'b0;
   endtask

   task automatic t_reset();
      logic [ADDR_W-1:0] a [10] = '{OFS_OWN, OFS_ENABLE, OFS_EDGE, OFS_POL, OFS_PRIO0,
                                    OFS_PRIO1, OFS_PEND, OFS_STATUS, OFS_MASK, 8'h30};
      logic [DATA_W-1:0] e [10] = '{32'(RST_OWN), 32'(RST_ENABLE), 32'(RST_EDGE),
                                    32'(RST_POL), 32'(RST_PRIO[23:0]), 32'(RST_PRIO[47:24]),
                                    32'h0, 32'(RST_STS), 32'(RST_STS), 32'h0};
      for (int i = 0; i < 10; i++) rdc(a[i], e[i], "reset value");
      check("owns", 32'h1F, 32'(owns));
      check("fast out", 32'h1, 32'(fast_n));
   endtask

   task automatic t_route();
      ext_fast_request <= 1'b1;
      int_src <= '1;
      wr(OFS_ENABLE, 32'hFFFF);
      cyc(6);
      check("fast unowned", 32'h1, 32'(fast_n));
      check("std any", 32'h0, 32'(std_n));
      wr(OFS_OWN, 32'h10);
      cyc(6);
      check("owns", 32'h0F, 32'(owns));
      check("fast owned", 32'h0, 32'(fast_n));
      rdc(OFS_STATUS, 32'h3, "status");
      ext_fast_request <= 1'b0;
      cyc(6);
      check("fast from sources", 32'h1, 32'(fast_n));
      wr(OFS_ENABLE, 32'h0);
      cyc(4);
      check("std masked", 32'h1, 32'(std_n));
      int_src <= '0;
      wr(OFS_OWN, 32'h01);
      wr(OFS_ENABLE, 32'h1000);
      ext_std_request <= 4'h1;
      cyc(6);
      check("std ext pin", 32'h0, 32'(std_n));
      wr(OFS_OWN, 32'h00);
      cyc(6);
      check("std pin unowned", 32'h1, 32'(std_n));
      ext_std_request <= 4'h0;
      wr(OFS_ENABLE, 32'h0);
      wr(OFS_STATUS, 32'h3);
   endtask

   task automatic t_vector();
      logic [DATA_W-1:0] en [5] = '{32'h12A, 32'h2A, 32'h22, 32'h02, 32'h00};
      logic [DATA_W-1:0] ev [5] = '{32'h80000708, 32'h80000603, 32'h80000605,
                                    32'h80000301, 32'h0};
      // src1 prio 3, src3 and src5 prio 6, src8 prio 7
      wr(OFS_PRIO0, 32'h30C18);
      wr(OFS_PRIO1, 32'h7);
      rdc(OFS_PRIO1, 32'h7, "prio1 back");
      int_src <= 12'h12A;
      wr(OFS_ENABLE, 32'h2A);
      ack_wait <= 4'h9;
      take_vector();
      check("core vector", 32'h3, 32'(taken_src));
      check("core prio", 32'h6, 32'(vec_prio));
      check("core valid", 32'h1, 32'(vec_valid));
      for (int i = 0; i < 5; i++) begin
         wr(OFS_ENABLE, en[i]);
         cyc(3);
         rdc(OFS_VECTOR, ev[i], "vector read");
      end
      int_src <= '0;
   endtask

   task automatic t_edge();
      wr(OFS_EDGE, 32'h1);
      wr(OFS_ENABLE, 32'h1);
      wr(OFS_MASK, 32'h1);
      wr(OFS_STATUS, 32'h3);
      int_src[0] <= 1'b1;
      cyc(1);
      int_src[0] <= 1'b0;
      cyc(4);
      rdc(OFS_PEND, 32'h1, "edge held");
      check("ctrl irq", 32'h1, 32'(ctrl_irq));
      ack_wait <= 4'h0;
      take_vector();
      check("edge vector", 32'h0, 32'(taken_src));
      cyc(2);
      rdc(OFS_PEND, 32'h0, "edge acked");
      check("std idle", 32'h1, 32'(std_n));
      wr(OFS_MASK, 32'h0);
      cyc(2);
      check("irq masked", 32'h0, 32'(ctrl_irq));
      wr(OFS_MASK, 32'h1);
      cyc(2);
      check("irq unmasked", 32'h1, 32'(ctrl_irq));
      wr(OFS_STATUS, 32'h1);
      cyc(3);
      check("irq cleared", 32'h0, 32'(ctrl_irq));
      wr(OFS_EDGE, 32'h0);
      int_src[0] <= 1'b1;
      cyc(3);
      rdc(OFS_PEND, 32'h1, "level on");
      int_src[0] <= 1'b0;
      cyc(3);
      rdc(OFS_PEND, 32'h0, "level off");
   endtask

   task automatic t_ext();
      logic e;
      logic p;
      wr(OFS_OWN, 32'h01);
      // modes in turn: falling edge, rising edge, low level, high level
      for (int m = 3; m >= 0; m--) begin
         e = m[1];
         p = ~m[0];
         ext_std_request[0] <= ~p;
         wr(OFS_EDGE, 32'(e) << 12);
         wr(OFS_POL, 32'hEFFF | (32'(p) << 12));
         cyc(6);
         wr(OFS_PEND, 32'h1000);
         rdc(OFS_PEND, 32'h0, "ext idle");
         ext_std_request[0] <= p;
         cyc(6);
         rdc(OFS_PEND, 32'h1000, "ext active");
         ext_std_request[0] <= ~p;
         cyc(6);
         rdc(OFS_PEND, 32'(e) << 12, "ext released");
      end
   endtask

   task automatic t_hold();
      wr(OFS_ENABLE, 32'h1);
      clk_en <= 1'b0;
      int_src[0] <= 1'b1;
      cyc(4);
      check("std frozen", 32'h1, 32'(std_n));
      clk_en <= 1'b1;
      cyc(4);
      check("std resumed", 32'h0, 32'(std_n));
      int_src[0] <= 1'b0;
      wr(OFS_ENABLE, 32'h0);
      cyc(3);
      check("std after hold", 32'h1, 32'(std_n));
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      cyc(8);
      sys_rst <= 1'b0;
      t_reset();
      t_route();
      t_vector();
      t_edge();
      t_ext();
      t_hold();
      print_verdict();
   end

   initial begin
      #100us;
      n_mismatch++;
      print_verdict();
   end
endmodule
`default_nettype wire
